// ---- rtl/mpa_access_map.sv ----
// Peripheral-mode address decoder and register bank of the translation unit.
//
// How it works
// [R1] Address bits 11..8 select the entity; bit 8 is least significant.
// [R2] Index picks an element; descriptor caches use only address bit 2.
// [R3] Section RAMs use address bits 2 and 3 for one of four entries.
// [R4] Single registers ignore the index; every index reaches the register.
// [R5] Sixteen entity codes map caches, flush, RAMs, fault, config, readbacks.
// [R6] Address bits 1..0 and 31..12 are ignored during decoding.
// [R7] A failed translation raises a fault.
// [R8] A fault records its cause code in the fault-type field.
// [R9] A fault captures the faulting virtual address.
// [R10] Chip select and data strobe both low request an access; the addressed object is read or written.
// [R11] Ready acknowledge is asserted to complete each access.
// [R12] Ready stays asserted until strobe or chip select negates, then drops.
// [R13] Writes to read-only/reserved do nothing; write-only/reserved read zero.
module mpa_access_map (
  // Clock, reset and enable.
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              ce_in,
  // CPU bus pins.
  input  wire logic              unit_chip_select_n_in,
  input  wire logic              data_strobe_n_in,
  input  wire logic              rd_in,
  input  wire logic [31:0]       addr_in,
  input  wire logic [31:0]       data_in,
  output logic      [31:0]       data_out,
  output logic                   data_oe_out,
  output logic                   slave_ready_ack_n_out,
  // Translation logic side.
  input  wire mpa_pkg::mpa_fault_t fault_in,
  input  wire logic [31:0]       context_number_in,
  input  wire logic [31:0]       context_index_in,
  output logic                   fault_out,
  output logic      [31:0]       unit_configuration_out,
  output logic      [31:0]       virtual_address_out,
  output logic                   desc_flush_out,
  output logic      [31:0]       desc_flush_data_out,
  output logic                   ctx_flush_out,
  output logic      [31:0]       ctx_flush_data_out
);
  import mpa_pkg::*;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Entity field of an address; other upper and low bits play no part.
  function automatic logic [3:0] ent_of(input logic [31:0] a);
    ent_of = a[ENT_MSB:ENT_LSB];
  endfunction

  // Two-bit index of an address; caches pass one bit and registers none.
  function automatic logic [1:0] idx_of(input logic [31:0] a, input logic [1:0] w);
    logic [1:0] r;
    r = 2'h0;
    if (w >= 2'h1) begin
      r[0] = a[IDX_B0];
    end
    if (w == 2'h2) begin
      r[1] = a[IDX_B1];
    end
    idx_of = r;
  endfunction

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  mpa_bus_t   bus_m;
  mpa_bus_t   bus_s;
  mpa_state_t state;
  mpa_state_t next_state;

  // Two flops on every bus pin; only the second stage is read.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      bus_m <= '{cs_n: 1'b1, strobe_n: 1'b1, rd: 1'b0, addr: WORD_ZERO, wdata: WORD_ZERO};
      bus_s <= '{cs_n: 1'b1, strobe_n: 1'b1, rd: 1'b0, addr: WORD_ZERO, wdata: WORD_ZERO};
    end else if (ce_in) begin
      bus_m <= '{cs_n: unit_chip_select_n_in, strobe_n: data_strobe_n_in, rd: rd_in,
                 addr: addr_in, wdata: data_in};
      bus_s <= bus_m;
    end
  end

  // ****************************************************************
  // Decoding.
  // ****************************************************************
  wire logic       sel_act  = !bus_s.cs_n && !bus_s.strobe_n;      // R10
  wire logic       go       = sel_act && (state == ST_IDLE);
  wire logic [3:0] ent      = ent_of(bus_s.addr);                  // R1 R6
  wire logic       is_cache = (ent <= ENT_PAGE_HI);
  wire logic       is_sram  = (ent == ENT_SRAM_A) || (ent == ENT_SRAM_B);
  wire logic [1:0] idx_w    = is_sram ? 2'h2 : (is_cache ? 2'h1 : 2'h0);
  wire logic [1:0] idx      = idx_of(bus_s.addr, idx_w);           // R2 R3 R4
  wire logic       wr_go    = go && !bus_s.rd;
  wire logic       rd_go    = go && bus_s.rd;

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [31:0] seg_lo [2];
  logic [31:0] seg_hi [2];
  logic [31:0] page_lo [2];
  logic [31:0] page_hi [2];
  logic [31:0] sram_a [4];
  logic [31:0] sram_b [4];
  logic [31:0] fcode;
  logic [31:0] faddr;
  logic [31:0] cfg;
  logic [31:0] vaddr;
  logic [31:0] rd_word;

  // Descriptor caches and section RAMs, written on a decoded write.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      seg_lo  <= '{default: WORD_ZERO};
      seg_hi  <= '{default: WORD_ZERO};
      page_lo <= '{default: WORD_ZERO};
      page_hi <= '{default: WORD_ZERO};
      sram_a <= '{default: WORD_ZERO};
      sram_b <= '{default: WORD_ZERO};
    end else if (ce_in && wr_go) begin
      case (ent)                                                   // R5
        ENT_SEG_LO:  seg_lo[idx[0]] <= bus_s.wdata;                // R2
        ENT_SEG_HI:  seg_hi[idx[0]] <= bus_s.wdata;
        ENT_PAGE_LO: page_lo[idx[0]] <= bus_s.wdata;
        ENT_PAGE_HI: page_hi[idx[0]] <= bus_s.wdata;
        ENT_SRAM_A: sram_a[idx] <= bus_s.wdata;                    // R3
        ENT_SRAM_B: sram_b[idx] <= bus_s.wdata;
        default: ;
      endcase
    end
  end

  // Single registers; a fault report beats a CPU write to fcode or faddr in the same cycle.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fcode <= WORD_ZERO;
      faddr <= WORD_ZERO;
      cfg   <= WORD_ZERO;
      vaddr <= WORD_ZERO;
    end else if (ce_in) begin
      if (fault_in.req) begin
        fcode        <= WORD_ZERO;
        fcode[FT_MSB:0] <= fault_in.ftype;                         // R8
        faddr        <= fault_in.vaddr;                            // R9
      end else if (wr_go && ent == ENT_FCODE) begin
        fcode <= bus_s.wdata;                                      // R4
      end else if (wr_go && ent == ENT_FADDR) begin
        faddr <= bus_s.wdata;
      end
      if (wr_go && ent == ENT_CONFIG) begin
        cfg <= bus_s.wdata;                                        // R4
      end
      if (wr_go && ent == ENT_VADDR) begin
        vaddr <= bus_s.wdata;
      end
    end
  end

  // Fault event and the two write-only flush commands, as pulses.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fault_out           <= 1'b0;
      desc_flush_out      <= 1'b0;
      ctx_flush_out       <= 1'b0;
      desc_flush_data_out <= WORD_ZERO;
      ctx_flush_data_out  <= WORD_ZERO;
    end else if (ce_in) begin
      fault_out      <= fault_in.req;                              // R7
      desc_flush_out <= wr_go && (ent == ENT_DFLUSH);
      ctx_flush_out  <= wr_go && (ent == ENT_CTXFL);
      if (wr_go && ent == ENT_DFLUSH) begin
        desc_flush_data_out <= bus_s.wdata;
      end
      if (wr_go && ent == ENT_CTXFL) begin
        ctx_flush_data_out <= bus_s.wdata;
      end
    end
  end

  assign unit_configuration_out = cfg;
  assign virtual_address_out    = vaddr;

  // ****************************************************************
  // Read path.
  // ****************************************************************

  // Selects the read word; write-only and reserved codes read zero.
  always_comb begin
    case (ent)                                                     // R5
      ENT_SEG_LO:  rd_word = seg_lo[idx[0]];
      ENT_SEG_HI:  rd_word = seg_hi[idx[0]];
      ENT_PAGE_LO: rd_word = page_lo[idx[0]];
      ENT_PAGE_HI: rd_word = page_hi[idx[0]];
      ENT_SRAM_A:  rd_word = sram_a[idx];
      ENT_SRAM_B:  rd_word = sram_b[idx];
      ENT_FCODE:   rd_word = fcode;
      ENT_FADDR:   rd_word = faddr;
      ENT_CONFIG:  rd_word = cfg;
      ENT_VADDR:   rd_word = vaddr;
      ENT_CTXNUM:  rd_word = context_number_in;
      ENT_CTXIDX:  rd_word = context_index_in;
      ENT_VERSION: rd_word = VERSION_CODE;
      default:     rd_word = WORD_ZERO;                            // R13
    endcase
  end

  // ****************************************************************
  // Handshake.
  // ****************************************************************

  // Leaves the acknowledge state once strobe or chip select negates.
  always_comb begin
    case (state)
      ST_IDLE: next_state = sel_act ? ST_ACK : ST_IDLE;            // R10
      ST_ACK:  next_state = sel_act ? ST_ACK : ST_IDLE;            // R12
      default: next_state = ST_IDLE;
    endcase
  end

  // State, acknowledge and registered read data.
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state                 <= ST_IDLE;
      slave_ready_ack_n_out <= 1'b1;
      data_out              <= WORD_ZERO;
      data_oe_out           <= 1'b0;
    end else if (ce_in) begin
      state                 <= next_state;
      slave_ready_ack_n_out <= !(next_state == ST_ACK);            // R11 R12
      data_oe_out           <= (next_state == ST_ACK) && bus_s.rd;
      if (rd_go) begin
        data_out <= rd_word;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  AST_ACK_START: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R11
    go |=> !slave_ready_ack_n_out)
    else $error("Acknowledge not raised after a selected access.");

  AST_ACK_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R12
    (state == ST_ACK) && sel_act |=> !slave_ready_ack_n_out)
    else $error("Acknowledge dropped while strobe and select still active.");

  AST_ACK_DROP: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R12
    !slave_ready_ack_n_out && !sel_act |=> slave_ready_ack_n_out ##1 slave_ready_ack_n_out)
    else $error("Acknowledge kept after strobe or select negated.");

  AST_FAULT_PULSE: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R7
    fault_in.req |=> fault_out)
    else $error("Fault not raised for a failed translation.");

  AST_FAULT_CODE: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R8
    fault_in.req |=> fcode == {27'h0, $past(fault_in.ftype)})
    else $error("Fault type not recorded.");

  AST_FAULT_ADDR: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R9
    fault_in.req |=> faddr == $past(fault_in.vaddr))
    else $error("Faulting address not captured.");

  AST_CFG_ANY_IDX: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R4
    wr_go && ent == ENT_CONFIG |=> unit_configuration_out == $past(bus_s.wdata))
    else $error("Configuration write lost for some index.");

  AST_SRAM_ENTRY: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R3
    wr_go && ent == ENT_SRAM_A |=> sram_a[$past(bus_s.addr[IDX_B1:IDX_B0])]
      == $past(bus_s.wdata))
    else $error("Section RAM entry not chosen by address bits 3..2.");

  AST_CACHE_BIT2: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R2
    wr_go && ent == ENT_SEG_LO |=> seg_lo[$past(bus_s.addr[IDX_B0])] == $past(bus_s.wdata))
    else $error("Descriptor cache element not chosen by address bit 2.");

  AST_WO_READ_ZERO: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R13
    rd_go && (ent == ENT_DFLUSH || ent == ENT_RSVD || ent == ENT_CTXFL)
      |=> data_out == WORD_ZERO)
    else $error("Write-only or reserved entity read nonzero.");

  AST_ENTITY_FIELD: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R1
    rd_go && bus_s.addr[ENT_MSB:ENT_LSB] == ENT_VERSION |=> data_out == VERSION_CODE)
    else $error("Entity field decode wrong.");

  AST_DFLUSH_PULSE: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R5
    desc_flush_out |=> !desc_flush_out)
    else $error("Descriptor flush pulse lasted more than one cycle.");

  AST_CFLUSH_PULSE: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R5
    ctx_flush_out |=> !ctx_flush_out)
    else $error("Context flush pulse lasted more than one cycle.");

  AST_RO_WRITE_KEEPS: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R13
    wr_go && (ent == ENT_RSVD || ent == ENT_CTXNUM || ent == ENT_CTXIDX || ent == ENT_VERSION)
      |=> $stable(cfg) && $stable(vaddr))
    else $error("Write to a read-only or reserved entity changed a register.");

  AST_READ_DRIVES: assert property (@(posedge clk_in) disable iff (!nrst_in || !ce_in) // R11
    rd_go |=> data_oe_out)
    else $error("Read acknowledged without driving the data bus.");

endmodule

// ---- rtl/mpa_pkg.sv ----
// Package with the constants and types of the peripheral-mode access map.
package mpa_pkg;

  // ****************************************************************
  // Address field layout.
  // ****************************************************************
  localparam int unsigned ENT_LSB  = 8;
  localparam int unsigned ENT_MSB  = 11;
  localparam int unsigned IDX_B0   = 2;
  localparam int unsigned IDX_B1   = 3;
  localparam int unsigned FT_MSB   = 4;

  // ****************************************************************
  // Entity codes.
  // ****************************************************************
  localparam logic [3:0] ENT_SEG_LO  = 4'h0;
  localparam logic [3:0] ENT_SEG_HI  = 4'h1;
  localparam logic [3:0] ENT_PAGE_LO = 4'h2;
  localparam logic [3:0] ENT_PAGE_HI = 4'h3;
  localparam logic [3:0] ENT_DFLUSH  = 4'h4;
  localparam logic [3:0] ENT_RSVD    = 4'h5;
  localparam logic [3:0] ENT_SRAM_A  = 4'h6;
  localparam logic [3:0] ENT_SRAM_B  = 4'h7;
  localparam logic [3:0] ENT_FCODE   = 4'h8;
  localparam logic [3:0] ENT_FADDR   = 4'h9;
  localparam logic [3:0] ENT_CONFIG  = 4'ha;
  localparam logic [3:0] ENT_VADDR   = 4'hb;
  localparam logic [3:0] ENT_CTXNUM  = 4'hc;
  localparam logic [3:0] ENT_CTXIDX  = 4'hd;
  localparam logic [3:0] ENT_CTXFL   = 4'he;
  localparam logic [3:0] ENT_VERSION = 4'hf;

  // ****************************************************************
  // Reset values and identity.
  // ****************************************************************
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
  localparam logic [4:0]  FT_NONE      = 5'h00;
  // Arbitrary version code, not tied to any real part.
  localparam logic [31:0] VERSION_CODE = 32'h0000_0001;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } mpa_state_t;

  // Bus pins of one peripheral-mode access, sampled together.
  typedef struct packed {
    logic        cs_n;
    logic        strobe_n;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mpa_bus_t;

  // Fault report from the translation logic.
  typedef struct packed {
    logic        req;
    logic [4:0]  ftype;
    logic [31:0] vaddr;
  } mpa_fault_t;

endpackage

// ---- verif/mpa_cpu_model.sv ----
// Host CPU model that makes peripheral-mode accesses on the unit's bus pins.
module mpa_cpu_model (
  // Clock.
  input  wire logic        clk_in,
  // Bus pins driven by the host.
  output logic             cs_n_out,
  output logic             strobe_n_out,
  output logic             rd_out,
  output logic [31:0]      addr_out,
  output logic [31:0]      wdata_out,
  // Answer from the unit.
  input  wire logic        ack_n_in,
  input  wire logic        oe_in,
  input  wire logic [31:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus: select and strobe negated, other lines parked.
  initial begin
    cs_n_out = 1'b1;
    strobe_n_out = 1'b1;
    rd_out = 1'b0;
    addr_out = 32'h0000_0000;
    wdata_out = 32'h0000_0000;
  end

  // One access: request held until the acknowledge is seen, then released.
  task automatic access(input logic rd, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = 32'h0000_0000;
    @(negedge clk_in);
    rd_out = rd;
    addr_out = a;
    wdata_out = d;
    cs_n_out = 1'b0;
    strobe_n_out = 1'b0;
    while (n < 20 && !ok) begin
      @(posedge clk_in);
      n++;
      if (ack_n_in === 1'b0) begin
        ok = 1'b1;
        q = (!rd || oe_in === 1'b1) ? rdata_in : 32'hxxxx_xxxx;
      end
    end
    // Released lines no longer show the old value.
    @(negedge clk_in);
    cs_n_out = 1'b1;
    strobe_n_out = 1'b1;
    rd_out = ~rd;
    addr_out = ~a;
    wdata_out = ~d;
    n = 0;
    while (n < 20 && ack_n_in !== 1'b1) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 20) ok = 1'b0;
  endtask
endmodule

// ---- verif/mpa_access_map_bench.sv ----
// Self-checking bench of the peripheral-mode access map.
module mpa_access_map_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mpa_pkg::*;

  // ****************************************************************
  // Signals and bench state.
  // ****************************************************************
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        cs_n, strobe_n, rd, oe, ack_n, flt, dfl, cfl;
  logic        ce = 1'b1;
  logic [31:0] addr, wdat, rdat, cfg, vad, dfd, cfd, got_dfl, got_cfl, va;
  logic [31:0] ctx_num = 32'h0000_0000;
  logic [31:0] ctx_idx = 32'h0000_0000;
  logic [31:0] rnd = 32'hd3c5099a;
  logic [31:0] mem [16][4];
  logic [4:0]  ft;
  mpa_fault_t  fault = '0;
  int          fails = 0, compares = 0;
  int          n_flt = 0, n_dfl = 0, n_cfl = 0, x_dfl = 0, x_cfl = 0;

  // Clock of 100 ns period.
  always #50 clk_in = ~clk_in;

  mpa_access_map mpa_access_map_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
    .unit_chip_select_n_in(cs_n), .data_strobe_n_in(strobe_n), .rd_in(rd),
    .addr_in(addr), .data_in(wdat), .data_out(rdat), .data_oe_out(oe),
    .slave_ready_ack_n_out(ack_n), .fault_in(fault), .context_number_in(ctx_num),
    .context_index_in(ctx_idx), .fault_out(flt), .unit_configuration_out(cfg),
    .virtual_address_out(vad), .desc_flush_out(dfl), .desc_flush_data_out(dfd),
    .ctx_flush_out(cfl), .ctx_flush_data_out(cfd));

  mpa_cpu_model mpa_cpu_model_i (
    .clk_in(clk_in), .cs_n_out(cs_n), .strobe_n_out(strobe_n), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdat), .ack_n_in(ack_n), .oe_in(oe), .rdata_in(rdat));

  // Pulse monitor: counts one-cycle pulses and keeps the data with them.
  always @(posedge clk_in) begin
    if (flt === 1'b1) n_flt++;
    if (dfl === 1'b1) begin
      n_dfl++;
      got_dfl = dfd;
    end
    if (cfl === 1'b1) begin
      n_cfl++;
      got_cfl = cfd;
    end
  end

  // ****************************************************************
  // Expectation helpers.
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  // Element within an entity: caches by bit 2, section RAMs by bits 3..2.
  function automatic int elem(input logic [3:0] e, input logic [31:0] a);
    if (e < ENT_DFLUSH) return int'(a[2]);
    if (e == ENT_SRAM_A || e == ENT_SRAM_B) return int'(a[3:2]);
    return 0;
  endfunction

  function automatic logic [31:0] exp_rd(input logic [3:0] e, input logic [31:0] a);
    case (e)
      ENT_DFLUSH, ENT_RSVD, ENT_CTXFL: return WORD_ZERO;
      ENT_CTXNUM: return ctx_num;
      ENT_CTXIDX: return ctx_idx;
      ENT_VERSION: return VERSION_CODE;
      default: return mem[e][elem(e, a)];
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One access with random junk in the ignored and index bits.
  task automatic rw(input logic r, input logic [3:0] e, input logic [31:0] d);
    logic [31:0] a, q;
    logic        ok;
    rnd = lfsr(rnd);
    a = {rnd[31:12], e, rnd[7:0]};
    mpa_cpu_model_i.access(r, a, d, q, ok);
    check("handshake", 32'h1, {31'h0, ok});
    if (r) check("read data", exp_rd(e, a), q);
    else if (!(e inside {ENT_DFLUSH, ENT_RSVD, ENT_CTXNUM, ENT_CTXIDX, ENT_CTXFL, ENT_VERSION}))
      mem[e][elem(e, a)] = d;
    if (!r && e == ENT_DFLUSH) begin
      x_dfl++;
      check("desc flush data", d, got_dfl);
    end
    if (!r && e == ENT_CTXFL) begin
      x_cfl++;
      check("ctx flush data", d, got_cfl);
    end
  endtask

  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung handshake.
  initial begin
    #2_000_000;
    fails++;
    test_done();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    foreach (mem[i, j]) mem[i][j] = WORD_ZERO;
    ctx_num = lfsr(rnd ^ 32'h1234_5678);
    ctx_idx = lfsr(ctx_num);
    repeat (4) @(negedge clk_in);
    nrst_in = 1'b1;
    check("idle ack", 32'h1, {31'h0, ack_n});
    // Every entity reads its reset or fixed value.
    for (int e = 0; e < 16; e++) rw(1'b1, e[3:0], 32'h0000_0000);
    // Writes to read-only, write-only and reserved places, then read back.
    for (int e = 12; e < 16; e++) begin
      rw(1'b0, e[3:0], ~VERSION_CODE);
      rw(1'b1, e[3:0], 32'h0000_0000);
    end
    rw(1'b0, ENT_RSVD, 32'hffff_ffff);
    rw(1'b1, ENT_RSVD, 32'h0000_0000);
    // Random traffic over all entities, back to back.
    repeat (160) begin
      rnd = lfsr(rnd);
      rw(rnd[4], rnd[11:8], lfsr(rnd));
    end
    check("config out", mem[ENT_CONFIG][0], cfg);
    check("vaddr out", mem[ENT_VADDR][0], vad);
    check("desc flush count", x_dfl, n_dfl);
    check("ctx flush count", x_cfl, n_cfl);
    // Faults: cause and address recorded, one pulse each.
    repeat (4) begin
      rnd = lfsr(rnd);
      ft = rnd[4:0];
      va = lfsr(rnd);
      @(negedge clk_in);
      fault = '{req: 1'b1, ftype: ft, vaddr: va};
      @(negedge clk_in);
      fault.req = 1'b0;
      mem[ENT_FCODE][0] = {27'h0, ft};
      mem[ENT_FADDR][0] = va;
      rw(1'b1, ENT_FCODE, 32'h0000_0000);
      rw(1'b1, ENT_FADDR, 32'h0000_0000);
    end
    // A fault report while the clock enable is low is not taken.
    @(negedge clk_in);
    ce = 1'b0;
    fault = '{req: 1'b1, ftype: ~ft, vaddr: ~va};
    @(negedge clk_in);
    fault.req = 1'b0;
    ce = 1'b1;
    rw(1'b1, ENT_FCODE, 32'h0000_0000);
    rw(1'b1, ENT_FADDR, 32'h0000_0000);
    check("fault pulses", 32'd4, n_flt);
    // Reset in mid-run clears every register and RAM.
    @(negedge clk_in);
    nrst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    nrst_in = 1'b1;
    foreach (mem[i, j]) mem[i][j] = WORD_ZERO;
    check("config after reset", WORD_ZERO, cfg);
    check("vaddr after reset", WORD_ZERO, vad);
    for (int e = 0; e < 16; e++) rw(1'b1, e[3:0], 32'h0000_0000);
    test_done();
  end
endmodule
